/* verilog/csr_pkg.sv */
/*
 * constants, register map, field layout and state types of the context status reporter.
 * assumes a 32-bit ahb-lite register bus and a 64-bit quadword memory write path.
 */
package csr_pkg;

	// register byte offsets on the ahb-lite bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CSB_MASK = 8'h04;
	localparam logic [7:0] OFF_PAGE_ADDR = 8'h08;
	localparam logic [7:0] OFF_LAST_WR = 8'h0c;
	localparam logic [7:0] OFF_ISR = 8'h10;
	localparam logic [7:0] OFF_IMR = 8'h14;
	localparam logic [7:0] OFF_SWM = 8'h18;
	localparam logic [7:0] OFF_EIR = 8'h1c;
	localparam logic [7:0] OFF_EMR = 8'h20;
	localparam logic [7:0] OFF_ESR = 8'h24;
	localparam logic [7:0] OFF_RING_START = 8'h28;
	localparam logic [7:0] OFF_RING_LEN = 8'h2c;
	localparam logic [7:0] OFF_PLACE = 8'h30;
	localparam logic [7:0] OFF_PREEMPT = 8'h34;

	// control register fields
	localparam int CTRL_ALLOW_POS = 0;
	localparam int CTRL_REPAIR_POS = 1;

	// interrupt vector bit positions
	localparam int IV_USER = 0;
	localparam int IV_MERR = 3;
	localparam int IV_FLUSH = 4;
	localparam int IV_PARITY = 5;
	localparam int IV_MEDIA = 6;
	localparam int IV_FAULT = 7;
	localparam int IV_CTXSW = 8;
	localparam int IV_W = 10;
	// bits that may reach a status-page interrupt report
	localparam logic [9:0] REPORT_ALLOW = 10'h028;

	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [15:0] CSB_MASK_RST = 16'h0000;
	localparam logic [9:0] IMR_RST = 10'h3ff;
	localparam logic [9:0] SWM_RST = 10'h3ff;
	localparam logic [15:0] EMR_RST = 16'hffff;

	// status buffer layout inside the global status page
	localparam int CSB_ENTRIES = 12;
	localparam logic [3:0] CSB_LAST_SLOT = 4'hb;
	localparam logic [31:0] CSB_BYTE_OFF = 32'h0000_00a0;
	localparam logic [31:0] QW15_BYTE_OFF = 32'h0000_0118;
	localparam int PAGE_SHIFT = 12;

	// status quadword fields
	localparam int CSQ_REASON_LSB = 0;
	localparam int CSQ_NEWQ_POS = 15;
	localparam int CSQ_AWAY_LSB = 32;
	localparam int CSQ_TO_LSB = 48;
	localparam logic [10:0] IDLE_CTXID = 11'h7ff;

	// placement limits
	localparam logic [31:0] RING_MAX_LEN = 32'h0020_0000;

	typedef enum logic [3:0] {
		WR_IDLE = 4'b0001,
		WR_SAVE = 4'b0010,
		WR_ENTRY = 4'b0100,
		WR_PTR = 4'b1000
	} csr_wr_state_type;

	typedef enum logic [3:0] {
		RS_IDLE = 4'b0001,
		RS_RESTORE = 4'b0010,
		RS_WA = 4'b0100,
		RS_RUN = 4'b1000
	} csr_rs_state_type;

endpackage

/* verilog/csr_top.sv */
/*
 * context status reporter: status buffer writer, report masking, interrupt vector,
 * error identity chain, preemption decision, restore sequencing and placement checks.
 * assumes one 50 mhz clock, an ahb-lite master, a memory write path with a one-cycle
 * ack, and a command decoder that pulses the preemptable-command events.
 */
// The register offsets and the AHB-Lite register port were left to the implementer.
// What this block does
// - status slots 0 to 11 form a ring, slot 0 follows slot 11
// - each unmasked switch writes quadword 15 low byte with the pre-increment pointer
// - pointer low four bits count writes; upper bits and quadwords 12-14 stay zero
// - switched-away context's status goes to the next ascending slot
// - a masked switch reason suppresses both the entry write and the interrupt
// - new submitted list preempts at next preemptable command, then switches
// - preempted context state is saved to its own state area
// - preemption points: arb check, element boundary, failed semaphore, failed event wait
// - per-context status page accesses are cacheable and snooped
// - global status page is 4KB aligned and written with global addresses
// - interrupt bit 8 marks a context switch
// - bit 7 follows a pending page fault; repair mode bypasses the mask
// - vector layout: 6 media, 5 parity, 4 flush, 3 master error, 0 user
// - status report carries master error and parity only; other bits report zero
// - error status reaches identity only where the mask allows
// - any identity bit sets the master error interrupt bit
// - identity bits clear on write of one, unrecoverable bits stay
// - workaround buffers run during restore, before any ring command
// - every reported switch reason is followed by a switch interrupt
// - each status quadword holds context identifiers and the switch reason
module csr_top #(
	parameter int ERR_W = 16,
	parameter logic [15:0] UNRECOV_MASK = 16'h8000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic cs_valid,
	input wire logic [3:0] cs_reason,
	input wire logic cs_new_queue,
	input wire logic [10:0] cs_ctx_away,
	input wire logic [10:0] cs_ctx_to,
	input wire logic cs_preempted,
	input wire logic [31:0] context_state_address,
	input wire logic [31:0] cs_resume_head,
	output logic cs_ready,
	output logic mem_req,
	output logic [31:0] mem_addr,
	output logic [63:0] mem_data,
	output logic [7:0] mem_be,
	output logic mem_snoop,
	output logic mem_global,
	input wire logic mem_ack,
	input wire logic list_submit,
	input wire logic arb_on,
	input wire logic arbitration_check_command,
	input wire logic elem_boundary,
	input wire logic sema_wait_fail,
	input wire logic event_wait_fail,
	output logic preempt,
	input wire logic restore_start,
	input wire logic restore_done,
	input wire logic wa_enabled,
	input wire logic wa_done,
	output logic wa_run,
	output logic ring_run,
	input wire logic fault_pending,
	input wire logic media_cnt_evt,
	input wire logic parity_evt,
	input wire logic flush_evt,
	input wire logic user_evt,
	input wire logic [ERR_W-1:0] error_status_reg,
	output logic irq,
	output logic [9:0] status_report
);

	logic ph_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic wr_en;
	logic [31:0] rd_mux;
	logic [1:0] ctrl_q;
	logic [15:0] csb_mask_q;
	logic [19:0] status_page_address_q;
	logic [9:0] isr_q;
	logic [9:0] imr_q;
	logic [9:0] status_write_mask_q;
	logic [ERR_W-1:0] error_identity_reg_q;
	logic [ERR_W-1:0] error_mask_reg_q;
	logic [31:0] ring_start_q;
	logic [31:0] ring_len_q;
	logic [3:0] ptr_q;
	logic [3:0] last_wr_q;
	logic pending_q;
	logic preempt_point;
	logic cs_accept;
	logic ctx_done;
	logic [63:0] status_qw_q;
	logic [31:0] save_addr_q;
	logic [31:0] save_data_q;
	logic [31:0] page_base;
	csr_pkg::csr_wr_state_type wst_q;
	csr_pkg::csr_rs_state_type rst_q;

	// ahb address phase capture; reads take one wait state so writes land first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			hreadyout <= 1'b1;
		end else begin
			if (hsel && htrans[1] && hready) begin
				ph_q <= 1'b1;
				wr_q <= hwrite;
				addr_q <= haddr[7:0];
				hreadyout <= hwrite;
			end else begin
				if (hreadyout) begin
					ph_q <= 1'b0;
				end
				hreadyout <= 1'b1;
			end
		end
	end

	assign wr_en = ph_q && wr_q && hreadyout;

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr_q)
			csr_pkg::OFF_CTRL: rd_mux = {30'h0, ctrl_q};
			csr_pkg::OFF_CSB_MASK: rd_mux = {16'h0, csb_mask_q};
			csr_pkg::OFF_PAGE_ADDR: rd_mux = {status_page_address_q, 12'h000};
			csr_pkg::OFF_LAST_WR: rd_mux = {20'h0, ptr_q, 4'h0, last_wr_q};
			csr_pkg::OFF_ISR: rd_mux = {22'h0, isr_q};
			csr_pkg::OFF_IMR: rd_mux = {22'h0, imr_q};
			csr_pkg::OFF_SWM: rd_mux = {22'h0, status_write_mask_q};
			csr_pkg::OFF_EIR: rd_mux = 32'(error_identity_reg_q);
			csr_pkg::OFF_EMR: rd_mux = 32'(error_mask_reg_q);
			csr_pkg::OFF_ESR: rd_mux = 32'(error_status_reg);
			csr_pkg::OFF_RING_START: rd_mux = ring_start_q;
			csr_pkg::OFF_RING_LEN: rd_mux = ring_len_q;
			csr_pkg::OFF_PLACE: begin
				rd_mux[0] = |ring_start_q[11:0];
				rd_mux[1] = ring_len_q > csr_pkg::RING_MAX_LEN;
			end
			csr_pkg::OFF_PREEMPT: rd_mux = {28'h0, rst_q == csr_pkg::RS_WA, ring_run, pending_q,
				wst_q != csr_pkg::WR_IDLE};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data and response; the response is always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (ph_q && !wr_q && !hreadyout) begin
				hrdata <= rd_mux;
			end
		end
	end

	// plain software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= csr_pkg::CTRL_RST;
			csb_mask_q <= csr_pkg::CSB_MASK_RST;
			status_page_address_q <= 20'h00000;
			imr_q <= csr_pkg::IMR_RST;
			status_write_mask_q <= csr_pkg::SWM_RST;
			error_mask_reg_q <= ERR_W'(csr_pkg::EMR_RST);
			ring_start_q <= 32'h0000_0000;
			ring_len_q <= 32'h0000_0000;
		end else if (wr_en) begin
			case (addr_q)
				csr_pkg::OFF_CTRL: ctrl_q <= hwdata[1:0];
				csr_pkg::OFF_CSB_MASK: csb_mask_q <= hwdata[15:0];
				csr_pkg::OFF_PAGE_ADDR: status_page_address_q <= hwdata[31:12];
				csr_pkg::OFF_IMR: imr_q <= hwdata[9:0];
				csr_pkg::OFF_SWM: status_write_mask_q <= hwdata[9:0];
				csr_pkg::OFF_EMR: error_mask_reg_q <= hwdata[ERR_W-1:0];
				csr_pkg::OFF_RING_START: ring_start_q <= hwdata;
				csr_pkg::OFF_RING_LEN: ring_len_q <= hwdata;
				default: ;
			endcase
		end
	end

	// error identity: masked forwarding, write-one clear, set wins, sticky unrecoverable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			error_identity_reg_q <= '0;
		end else begin
			error_identity_reg_q <= (error_identity_reg_q
				& ~((wr_en && addr_q == csr_pkg::OFF_EIR) ? hwdata[ERR_W-1:0]
				& ~ERR_W'(UNRECOV_MASK) : '0))
				| (error_status_reg & ~error_mask_reg_q);
		end
	end

	// interrupt vector; sticky events clear on write of one, set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			isr_q <= 10'h000;
		end else begin
			if (wr_en && addr_q == csr_pkg::OFF_ISR) begin
				isr_q[csr_pkg::IV_CTXSW] <= isr_q[csr_pkg::IV_CTXSW] & ~hwdata[csr_pkg::IV_CTXSW];
				isr_q[csr_pkg::IV_MEDIA] <= isr_q[csr_pkg::IV_MEDIA] & ~hwdata[csr_pkg::IV_MEDIA];
				isr_q[csr_pkg::IV_PARITY] <= isr_q[csr_pkg::IV_PARITY]
					& ~hwdata[csr_pkg::IV_PARITY];
				isr_q[csr_pkg::IV_FLUSH] <= isr_q[csr_pkg::IV_FLUSH] & ~hwdata[csr_pkg::IV_FLUSH];
				isr_q[csr_pkg::IV_USER] <= isr_q[csr_pkg::IV_USER] & ~hwdata[csr_pkg::IV_USER];
			end
			if (ctx_done) begin
				isr_q[csr_pkg::IV_CTXSW] <= 1'b1;
			end
			if (media_cnt_evt) begin
				isr_q[csr_pkg::IV_MEDIA] <= 1'b1;
			end
			if (parity_evt) begin
				isr_q[csr_pkg::IV_PARITY] <= 1'b1;
			end
			if (flush_evt) begin
				isr_q[csr_pkg::IV_FLUSH] <= 1'b1;
			end
			if (user_evt) begin
				isr_q[csr_pkg::IV_USER] <= 1'b1;
			end
			isr_q[csr_pkg::IV_FAULT] <= fault_pending;
			isr_q[csr_pkg::IV_MERR] <= |error_identity_reg_q;
			isr_q[9] <= 1'b0;
			isr_q[2] <= 1'b0;
			isr_q[1] <= 1'b0;
		end
	end

	// interrupt line and status-page report
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
			status_report <= 10'h000;
		end else begin
			irq <= |(isr_q & ~imr_q)
				| (ctrl_q[csr_pkg::CTRL_REPAIR_POS] & isr_q[csr_pkg::IV_FAULT]);
			status_report <= isr_q & ~status_write_mask_q & csr_pkg::REPORT_ALLOW;
		end
	end

	// preemption points under arbitration; element boundary and event wait also need allow-preemption
	assign preempt_point = arb_on && (arbitration_check_command || sema_wait_fail
		|| (ctrl_q[csr_pkg::CTRL_ALLOW_POS] && (elem_boundary || event_wait_fail)));

	// pending list submission; a new submit in the preempt cycle stays pending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_q <= 1'b0;
			preempt <= 1'b0;
		end else begin
			preempt <= pending_q && preempt_point;
			if (list_submit) begin
				pending_q <= 1'b1;
			end else if (preempt_point) begin
				pending_q <= 1'b0;
			end
		end
	end

	// restore sequencing: workaround buffers before ring commands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_q <= csr_pkg::RS_IDLE;
			wa_run <= 1'b0;
			ring_run <= 1'b0;
		end else begin
			case (rst_q)
				csr_pkg::RS_IDLE, csr_pkg::RS_RUN: begin
					if (restore_start) begin
						rst_q <= csr_pkg::RS_RESTORE;
						ring_run <= 1'b0;
					end
				end
				csr_pkg::RS_RESTORE: begin
					if (restore_done && wa_enabled) begin
						rst_q <= csr_pkg::RS_WA;
						wa_run <= 1'b1;
					end else if (restore_done) begin
						rst_q <= csr_pkg::RS_RUN;
						ring_run <= 1'b1;
					end
				end
				csr_pkg::RS_WA: begin
					if (wa_done) begin
						rst_q <= csr_pkg::RS_RUN;
						wa_run <= 1'b0;
						ring_run <= 1'b1;
					end
				end
				default: rst_q <= csr_pkg::RS_IDLE;
			endcase
		end
	end

	assign cs_accept = cs_valid && cs_ready;
	assign ctx_done = wst_q == csr_pkg::WR_PTR && mem_ack;
	assign page_base = {status_page_address_q, 12'h000};

	// status writer: optional state save, entry write, then pointer write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wst_q <= csr_pkg::WR_IDLE;
			cs_ready <= 1'b1;
			mem_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_data <= 64'h0;
			mem_be <= 8'h00;
			mem_snoop <= 1'b0;
			mem_global <= 1'b0;
			status_qw_q <= 64'h0;
			save_addr_q <= 32'h0000_0000;
			save_data_q <= 32'h0000_0000;
		end else begin
			case (wst_q)
				csr_pkg::WR_IDLE: begin
					if (cs_accept && !csb_mask_q[cs_reason]) begin
						cs_ready <= 1'b0;
						status_qw_q <= '0;
						status_qw_q[csr_pkg::CSQ_REASON_LSB +: 4] <= cs_reason;
						status_qw_q[csr_pkg::CSQ_NEWQ_POS] <= cs_new_queue;
						status_qw_q[csr_pkg::CSQ_AWAY_LSB +: 11] <= cs_ctx_away;
						status_qw_q[csr_pkg::CSQ_TO_LSB +: 11] <= cs_ctx_to;
						save_addr_q <= context_state_address;
						save_data_q <= cs_resume_head;
						mem_req <= 1'b1;
						if (cs_preempted) begin
							wst_q <= csr_pkg::WR_SAVE;
							mem_addr <= context_state_address;
							mem_data <= {21'h0, cs_ctx_away, cs_resume_head};
							mem_be <= 8'hff;
							mem_snoop <= 1'b1;
							mem_global <= 1'b0;
						end else begin
							wst_q <= csr_pkg::WR_ENTRY;
							mem_addr <= page_base + csr_pkg::CSB_BYTE_OFF + {25'h0, ptr_q, 3'h0};
							mem_data <= {5'h0, cs_ctx_to, 5'h0, cs_ctx_away, 16'h0,
								cs_new_queue, 11'h0, cs_reason};
							mem_be <= 8'hff;
							mem_snoop <= 1'b0;
							mem_global <= 1'b1;
						end
					end
				end
				csr_pkg::WR_SAVE: begin
					if (mem_ack) begin
						wst_q <= csr_pkg::WR_ENTRY;
						mem_addr <= page_base + csr_pkg::CSB_BYTE_OFF
							+ {25'h0, ptr_q, 3'h0};
						mem_data <= status_qw_q;
						mem_be <= 8'hff;
						mem_snoop <= 1'b0;
						mem_global <= 1'b1;
					end
				end
				csr_pkg::WR_ENTRY: begin
					if (mem_ack) begin
						wst_q <= csr_pkg::WR_PTR;
						mem_addr <= page_base + csr_pkg::QW15_BYTE_OFF;
						mem_data <= {60'h0, ptr_q};
						mem_be <= 8'h01;
					end
				end
				csr_pkg::WR_PTR: begin
					if (mem_ack) begin
						wst_q <= csr_pkg::WR_IDLE;
						mem_req <= 1'b0;
						mem_snoop <= 1'b0;
						mem_global <= 1'b0;
						cs_ready <= 1'b1;
					end
				end
				default: wst_q <= csr_pkg::WR_IDLE;
			endcase
		end
	end

	// ring pointer and last-written offset move only after the pointer write lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_q <= 4'h0;
			last_wr_q <= 4'h0;
		end else if (ctx_done) begin
			last_wr_q <= ptr_q;
			ptr_q <= (ptr_q == csr_pkg::CSB_LAST_SLOT) ? 4'h0 : ptr_q + 4'h1;
		end
	end

	AST_PTR_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
		ctx_done && ptr_q == csr_pkg::CSB_LAST_SLOT |=> ptr_q == 4'h0)
		else $error("status pointer did not wrap after slot 11");
	AST_QW15_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
		ctx_done |-> mem_data[3:0] == ptr_q && mem_be == 8'h01 ##1 last_wr_q == $past(ptr_q))
		else $error("pointer write does not carry pre-increment pointer");
	AST_PTR_UPPER_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		wst_q == csr_pkg::WR_PTR |-> mem_data[63:4] == 60'h0 && ptr_q < 4'hc)
		else $error("pointer quadword has nonzero upper bits");
	AST_ENTRY_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
		wst_q == csr_pkg::WR_ENTRY |-> mem_addr == page_base + csr_pkg::CSB_BYTE_OFF
		+ {25'h0, ptr_q, 3'h0} && mem_global && mem_addr[2:0] == 3'h0)
		else $error("status entry written to wrong slot");
	AST_MASK_SUPPRESS: assert property (@(posedge hclk) disable iff (!hresetn)
		wst_q == csr_pkg::WR_IDLE && cs_accept && csb_mask_q[cs_reason]
		|=> wst_q == csr_pkg::WR_IDLE && !mem_req)
		else $error("masked switch reason produced a write");
	AST_PREEMPT_POINT: assert property (@(posedge hclk) disable iff (!hresetn)
		pending_q && arb_on && arbitration_check_command |=> preempt ##1 !preempt || pending_q)
		else $error("no preemption at arbitration check");
	AST_NO_PREEMPT_ARB_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
		!arb_on |=> !preempt)
		else $error("preemption while arbitration off");
	AST_SAVE_SNOOP: assert property (@(posedge hclk) disable iff (!hresetn)
		wst_q == csr_pkg::WR_SAVE |-> mem_req && mem_snoop && !mem_global)
		else $error("context save not snooped");
	AST_CTX_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
		ctx_done |=> isr_q[csr_pkg::IV_CTXSW] ##1 irq || imr_q[csr_pkg::IV_CTXSW])
		else $error("context switch interrupt bit not set");
	AST_FAULT_REPAIR: assert property (@(posedge hclk) disable iff (!hresetn)
		fault_pending && ctrl_q[csr_pkg::CTRL_REPAIR_POS] ##1
		fault_pending && ctrl_q[csr_pkg::CTRL_REPAIR_POS] |=> irq)
		else $error("fault interrupt masked in repair mode");
	AST_EIR_FORWARD: assert property (@(posedge hclk) disable iff (!hresetn)
		error_status_reg[0] && !error_mask_reg_q[0] |=> error_identity_reg_q[0]
		##1 isr_q[csr_pkg::IV_MERR])
		else $error("unmasked error not forwarded");
	AST_REPORT_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		status_report[csr_pkg::IV_CTXSW] == 1'b0 && status_report[csr_pkg::IV_USER] == 1'b0
		&& status_report[csr_pkg::IV_FAULT] == 1'b0 && status_report[csr_pkg::IV_FLUSH] == 1'b0)
		else $error("status report carries a bit that must report zero");
	AST_WA_BEFORE_RING: assert property (@(posedge hclk) disable iff (!hresetn)
		rst_q == csr_pkg::RS_WA |-> !ring_run && wa_run)
		else $error("ring running during workaround buffer");

	COV_PREEMPTED_SWITCH: cover property (@(posedge hclk) disable iff (!hresetn)
		wst_q == csr_pkg::WR_SAVE ##[1:20] ctx_done);
	COV_WRAP: cover property (@(posedge hclk) disable iff (!hresetn)
		ctx_done && ptr_q == csr_pkg::CSB_LAST_SLOT);
	COV_PREEMPT: cover property (@(posedge hclk) disable iff (!hresetn) preempt);
	COV_WA_RUN: cover property (@(posedge hclk) disable iff (!hresetn)
		rst_q == csr_pkg::RS_WA ##[1:50] ring_run);

endmodule

/* verif/csr_mem.sv */
/* memory write path model: acks each quadword write after dly cycles and logs it.
   assumes the requester holds mem_req and its fields until the ack edge. */
module csr_mem (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [63:0] mem_data,
	input wire logic [7:0] mem_be,
	input wire logic mem_snoop,
	input wire logic mem_global,
	input wire logic [1:0] dly,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] la [16];
	logic [63:0] ld [16];
	logic [9:0] lf [16];
	int n;
	int w;
	// one-cycle ack after a wait; writes kept in arrival order
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			w <= 0;
			n <= 0;
		end else if (mem_ack || !mem_req) begin
			mem_ack <= 1'b0;
			w <= 0;
		end else if (w == int'(dly)) begin
			mem_ack <= 1'b1;
			la[n % 16] <= mem_addr;
			ld[n % 16] <= mem_data;
			lf[n % 16] <= {mem_be, mem_snoop, mem_global};
			n <= n + 1;
		end else begin
			w <= w + 1;
		end
	end
endmodule

/* verif/csr_top_tb.sv */
/* bench for the context status reporter: bus, switch events, errors, preemption.
   assumes the memory model csr_mem on the write path and a 50 mhz clock. */
module csr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, rd;
	logic [1:0] htrans = '0, dly = '0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, cs_ready, mem_req, mem_snoop, mem_global, mem_ack;
	logic cs_valid = 1'b0, cs_new_queue = 1'b1, cs_preempted = 1'b0, arb_on = 1'b0;
	logic wa_enabled = 1'b1, fault_pending = 1'b0, preempt, wa_run, ring_run, irq, seen;
	logic [3:0] cs_reason = '0;
	logic [10:0] cs_ctx_away = 11'h0ab, cs_ctx_to = 11'h7bc;
	// save area: quadword aligned, snooped write-back memory
	logic [31:0] context_state_address = 32'h0008_0040, cs_resume_head = 32'h1234;
	logic [31:0] hrdata, mem_addr;
	logic [63:0] mem_data;
	logic [7:0] mem_be;
	logic [9:0] status_report;
	logic [15:0] error_status_reg = '0;
	logic [11:0] pu = '0;
	logic [31:0] pg = 32'h0004_3000;
	int bad_count = 0, n_checks = 0, j;
	csr_top csr_top_i (.*, .hready(hreadyout), .list_submit(pu[0]),
		.arbitration_check_command(pu[1]), .elem_boundary(pu[2]), .sema_wait_fail(pu[3]),
		.event_wait_fail(pu[4]), .restore_start(pu[5]), .restore_done(pu[6]),
		.wa_done(pu[7]), .media_cnt_evt(pu[8]), .parity_evt(pu[9]), .flush_evt(pu[10]),
		.user_evt(pu[11]));
	csr_mem csr_mem_i (.*);
	// free-running clock
	always #10 hclk = ~hclk;
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for bus ready (s 0) or event ready (s 1)
	task automatic wt(input int s);
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (((s == 0) ? hreadyout : cs_ready) !== 1'b1 && k < 40);
		if (k >= 40) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// one single word transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt(0);
		htrans <= 2'h0;
		hwdata <= d;
		wt(0);
		rd = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		`CHK("register", e, rd)
	endtask
	// switch event held until taken, then wait for the writer to go idle
	task automatic ev(input logic [3:0] r, input logic p);
		cs_reason <= r;
		cs_preempted <= p;
		cs_valid <= 1'b1;
		wt(1);
		cs_valid <= 1'b0;
		@(posedge hclk);
		wt(1);
	endtask
	task automatic pulse(input logic [11:0] m);
		pu <= m;
		@(posedge hclk);
		pu <= '0;
	endtask
	// main sequence
	initial begin
		static logic [3:0] pt [7] = '{4'h8, 4'h9, 4'hd, 4'ha, 4'hb, 4'hf, 4'h4};
		static int pos [4] = '{6, 5, 4, 0};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(csr_pkg::OFF_IMR, 32'h3ff);
		rc(csr_pkg::OFF_EMR, 32'hffff);
		rc(8'h3c, 32'h0);
		ahb(1'b1, csr_pkg::OFF_PAGE_ADDR, pg);
		for (int i = 0; i < 13; i++) begin
			dly <= i[1:0];
			ev(4'h1, 1'b0);
			j = (csr_mem_i.n - 2) % 16;
			`CHK("entry", pg + 32'ha0 + 32'(8 * (i % 12)), csr_mem_i.la[j])
			`CHK("qword", 64'h07bc_00ab_0000_8001, csr_mem_i.ld[j])
			`CHK("ptr", pg + 32'h118, csr_mem_i.la[(j + 1) % 16])
			`CHK("ptrval", 64'(i % 12), csr_mem_i.ld[(j + 1) % 16])
			`CHK("ptrbe", 10'h005, csr_mem_i.lf[(j + 1) % 16])
			rc(csr_pkg::OFF_LAST_WR, {20'h0, 4'((i + 1) % 12), 4'h0, 4'(i % 12)});
		end
		$display("test ring done");
		ahb(1'b1, csr_pkg::OFF_CSB_MASK, 32'h8);
		ahb(1'b1, csr_pkg::OFF_ISR, 32'h100);
		j = csr_mem_i.n;
		ev(4'h3, 1'b0);
		`CHK("masked", j, csr_mem_i.n)
		rc(csr_pkg::OFF_ISR, 32'h0);
		ahb(1'b1, csr_pkg::OFF_IMR, 32'h2ff);
		ev(4'h1, 1'b1);
		j = (csr_mem_i.n - 3) % 16;
		`CHK("save", context_state_address, csr_mem_i.la[j])
		`CHK("savedata", 64'h0000_00ab_0000_1234, csr_mem_i.ld[j])
		`CHK("snoop", 2'b10, csr_mem_i.lf[j][1:0])
		repeat (2) @(posedge hclk);
		`CHK("irq", 1'b1, irq)
		ahb(1'b1, csr_pkg::OFF_ISR, 32'h100);
		repeat (2) @(posedge hclk);
		`CHK("irqclr", 1'b0, irq)
		$display("test switch done");
		ahb(1'b1, csr_pkg::OFF_EMR, 32'h7ffe);
		error_status_reg <= 16'h8003;
		ahb(1'b1, csr_pkg::OFF_SWM, 32'h0);
		repeat (3) @(posedge hclk);
		rc(csr_pkg::OFF_EIR, 32'h8001);
		`CHK("report", 10'h008, status_report)
		error_status_reg <= '0;
		ahb(1'b1, csr_pkg::OFF_EIR, 32'hffff);
		rc(csr_pkg::OFF_EIR, 32'h8000);
		for (int k = 0; k < 4; k++) begin
			pulse(12'h100 << k);
			repeat (2) @(posedge hclk);
			ahb(1'b0, csr_pkg::OFF_ISR, 32'h0);
			`CHK("vector", 1'b1, rd[pos[k]])
			`CHK("repzero", 2'b00, {status_report[4], status_report[0]})
		end
		$display("test error done");
		for (int i = 0; i < 7; i++) begin
			ahb(1'b1, csr_pkg::OFF_CTRL, {31'h0, pt[i][2]});
			arb_on <= pt[i][3];
			pulse(12'h1);
			@(posedge hclk);
			pulse(12'h2 << pt[i][1:0]);
			seen = 1'b0;
			repeat (3) begin
				@(posedge hclk);
				seen |= preempt;
			end
			`CHK("preempt", 7'b1011010 >> (6 - i) & 7'h1, 7'(seen))
		end
		pulse(12'h20);
		@(posedge hclk);
		pulse(12'h40);
		repeat (2) @(posedge hclk);
		`CHK("warun", 2'b10, {wa_run, ring_run})
		pulse(12'h80);
		repeat (2) @(posedge hclk);
		`CHK("ringrun", 2'b01, {wa_run, ring_run})
		wa_enabled <= 1'b0;
		pulse(12'h20);
		@(posedge hclk);
		`CHK("restoring", 2'b00, {wa_run, ring_run})
		pulse(12'h40);
		repeat (2) @(posedge hclk);
		`CHK("nowa", 2'b01, {wa_run, ring_run})
		ahb(1'b1, csr_pkg::OFF_RING_START, 32'h1800);
		ahb(1'b1, csr_pkg::OFF_RING_LEN, 32'h0020_0004);
		rc(csr_pkg::OFF_PLACE, 32'h3);
		ahb(1'b1, csr_pkg::OFF_RING_START, 32'h0004_5000);
		ahb(1'b1, csr_pkg::OFF_RING_LEN, 32'h0020_0000);
		rc(csr_pkg::OFF_PLACE, 32'h0);
		ahb(1'b1, csr_pkg::OFF_IMR, 32'h3ff);
		fault_pending <= 1'b1;
		repeat (3) @(posedge hclk);
		`CHK("faultmask", 1'b0, irq)
		ahb(1'b1, csr_pkg::OFF_CTRL, 32'h2);
		repeat (3) @(posedge hclk);
		`CHK("fault", 1'b1, irq)
		$display("test control done");
		tally_and_finish();
	end
endmodule
